/* File: ctr_defines.svh */
// Purpose: Register offsets, field positions, reset values and counts for the clamp block
// Assumes: Byte-wide registers reached by a simple write/read register port
// Notes:   Definitions only
`ifndef CTR_DEFINES_SVH
`define CTR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CTR_ADDR_CLAMP_CFG    5'h07
`define CTR_ADDR_FINE_CTL     5'h08
`define CTR_ADDR_COARSE_CTL   5'h09
`define CTR_ADDR_TIMING       5'h0a
`define CTR_ADDR_REFADJ       5'h0b
`define CTR_ADDR_AUX_BASE     5'h10
`define CTR_ADDR_AUX_LAST     5'h17
`define CTR_ADDR_MODE3        5'h03

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTR_FINE_DUR_LSB      0
`define CTR_COARSE_DUR_LSB    3
`define CTR_SYNC_SEL_BIT      6
`define CTR_EDGE_POL_BIT      5
`define CTR_DELAY_LSB         5
`define CTR_TRIM_LSB          4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTR_RST_BYTE          8'h00
`define CTR_RST_REFADJ        8'h01
`define CTR_RST_COUNT         9'h000
`define CTR_COUNT_ONE         9'h001

`endif

/* File: ctr_pkg.sv */
// Purpose: Types shared by the clamp trigger and configuration register block
// Assumes: Constants live in ctr_defines.svh
// Notes:   Structs carry grouped signals
package ctr_pkg;

    // Register access request from the serial bus front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ctr_req_s;

    // Per-clamp drive: on and direction
    typedef struct packed {
        logic on;
        logic up;
    } ctr_clamp_s;

endpackage

/* File: ctr_aux_mem.sv */
// Purpose: Eight byte store for auxiliary conversion results
// Assumes: One write port from the converter, one registered read port
// Notes:   Read data come out of a register
module ctr_aux_mem
    import ctr_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          clk_sys_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);

    logic [7:0] mem [DEPTH];

    // Converter writes a result
    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read
    always_ff @(posedge clk_sys_i) begin
        rdata_o <= mem[raddr_i];
    end

endmodule // ctr_aux_mem

/* File: ctr_clamp_regs.sv */
// Purpose: Clamp trigger logic with timing, reference trim and aux monitor registers
// Assumes: Host accesses arrive as a one-cycle request on the core clock
// Notes:   Sync pin is synchronised; read data valid two cycles after rd
`include "ctr_defines.svh"

module ctr_clamp_regs
    import ctr_pkg::*;
#(
    parameter int NCLAMP = 3
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire ctr_req_s    req_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o,
    input  wire logic        sync_in_i,
    input  wire logic        aux_we_i,
    input  wire logic [2:0]  aux_sel_i,
    input  wire logic [7:0]  aux_data_i,
    output logic      [1:0]  core_clock_delay_sel_o,
    output logic      [2:0]  adc_reference_trim_o,
    output ctr_clamp_s [NCLAMP-1:0] fine_clamp_o,
    output ctr_clamp_s [NCLAMP-1:0] coarse_clamp_o
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] clamp_cfg_r;
    logic [7:0] fine_ctl_r;
    logic [7:0] coarse_ctl_r;
    logic [7:0] core_timing_control_r;
    logic [7:0] adc_reference_adjust_r;
    logic [7:0] mode3_r;
    logic [7:0] aux_rdata;
    logic [7:0] rdata_nxt;
    logic       rd_aux_r;
    logic       sync_meta_r;
    logic       sync_r;
    logic       sync_d_r;
    logic       sync_edge;

    // Decode used for both write and read
    function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
        return a == b;
    endfunction

    // Host writes; reserved bits stored as written, host keeps them legal
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            clamp_cfg_r            <= `CTR_RST_BYTE;
            fine_ctl_r             <= `CTR_RST_BYTE;
            coarse_ctl_r           <= `CTR_RST_BYTE;
            core_timing_control_r  <= `CTR_RST_BYTE;
            adc_reference_adjust_r <= `CTR_RST_REFADJ;
            mode3_r                <= `CTR_RST_BYTE;
        end else if (req_i.wr) begin
            if (hit(req_i.addr, `CTR_ADDR_CLAMP_CFG)) begin
                clamp_cfg_r <= req_i.wdata;
            end else if (hit(req_i.addr, `CTR_ADDR_FINE_CTL)) begin
                fine_ctl_r <= req_i.wdata;
            end else if (hit(req_i.addr, `CTR_ADDR_COARSE_CTL)) begin
                coarse_ctl_r <= req_i.wdata;
            end else if (hit(req_i.addr, `CTR_ADDR_TIMING)) begin
                core_timing_control_r <= req_i.wdata;
            end else if (hit(req_i.addr, `CTR_ADDR_REFADJ)) begin
                adc_reference_adjust_r <= req_i.wdata;
            end else if (hit(req_i.addr, `CTR_ADDR_MODE3)) begin
                mode3_r <= req_i.wdata;
            end
        end
    end

    // Configuration outputs
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            core_clock_delay_sel_o <= 2'h0;
            adc_reference_trim_o   <= 3'h0;
        end else begin
            core_clock_delay_sel_o <= core_timing_control_r[`CTR_DELAY_LSB +: 2];
            adc_reference_trim_o   <= adc_reference_adjust_r[`CTR_TRIM_LSB +: 3];
        end
    end

    // ------------------------------------------------------------------
    // Aux monitor store and read path
    // ------------------------------------------------------------------
    ctr_aux_mem #(
        .DEPTH (8),
        .AW    (3)
    ) u_aux (
        .clk_sys_i (clk_sys_i),
        .we_i      (aux_we_i),
        .waddr_i   (aux_sel_i),
        .wdata_i   (aux_data_i),
        .raddr_i   (req_i.addr[2:0]),
        .rdata_o   (aux_rdata)
    );

    // Local register read mux; aux range selected later
    always_comb begin
        rdata_nxt = 8'h00;
        if (hit(req_i.addr, `CTR_ADDR_CLAMP_CFG)) begin
            rdata_nxt = clamp_cfg_r;
        end else if (hit(req_i.addr, `CTR_ADDR_FINE_CTL)) begin
            rdata_nxt = fine_ctl_r;
        end else if (hit(req_i.addr, `CTR_ADDR_COARSE_CTL)) begin
            rdata_nxt = coarse_ctl_r;
        end else if (hit(req_i.addr, `CTR_ADDR_TIMING)) begin
            rdata_nxt = core_timing_control_r;
        end else if (hit(req_i.addr, `CTR_ADDR_REFADJ)) begin
            rdata_nxt = adc_reference_adjust_r;
        end else if (hit(req_i.addr, `CTR_ADDR_MODE3)) begin
            rdata_nxt = mode3_r;
        end
    end

    logic [7:0] local_rdata_r;
    logic       rd_pend_r;

    // Stage one: capture local data and aux flag
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            local_rdata_r <= 8'h00;
            rd_aux_r      <= 1'b0;
            rd_pend_r     <= 1'b0;
        end else begin
            local_rdata_r <= rdata_nxt;
            rd_aux_r      <= (req_i.addr >= `CTR_ADDR_AUX_BASE)
                             && (req_i.addr <= `CTR_ADDR_AUX_LAST);
            rd_pend_r     <= req_i.rd;
        end
    end

    // Stage two: answer two cycles after rd
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_pend_r;
            if (rd_pend_r) begin
                rdata_o <= rd_aux_r ? aux_rdata : local_rdata_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sync input synchroniser and edge detect
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sync_meta_r <= 1'b0;
            sync_r      <= 1'b0;
            sync_d_r    <= 1'b0;
        end else begin
            sync_meta_r <= sync_in_i;
            sync_r      <= sync_meta_r;
            sync_d_r    <= sync_r;
        end
    end

    // Polarity bit picks rising or falling edge
    assign sync_edge = mode3_r[`CTR_EDGE_POL_BIT] ? (sync_r & ~sync_d_r)
                                                  : (~sync_r & sync_d_r);

    // ------------------------------------------------------------------
    // Clamp engines, fine then coarse
    // ------------------------------------------------------------------
    logic       sync_sel;
    logic [2:0] fine_code;
    logic [2:0] coarse_code;
    assign sync_sel    = clamp_cfg_r[`CTR_SYNC_SEL_BIT];
    assign fine_code   = clamp_cfg_r[`CTR_FINE_DUR_LSB +: 3];
    assign coarse_code = clamp_cfg_r[`CTR_COARSE_DUR_LSB +: 3];

    // Cycle count for a duration code: 2 to the k+1
    // Shift amount is four bits wide so that code 7 gives 256 rather than wrapping to 1
    function automatic logic [8:0] dur_cycles(input logic [2:0] k);
        return 9'(`CTR_COUNT_ONE << ({1'b0, k} + 4'h1));
    endfunction

    genvar g, c;
    generate
        for (g = 0; g < 2; g++) begin : g_grp
            for (c = 0; c < NCLAMP; c++) begin : g_clamp
                logic       en_bit;
                logic       dir_bit;
                logic       en_d_r;
                logic       armed_r;
                logic       on_r;
                logic [8:0] cnt_r;
                logic [8:0] limit;
                logic       fire;

                assign en_bit  = (g == 0) ? fine_ctl_r[2*c+1] : coarse_ctl_r[2*c+1];
                assign dir_bit = (g == 0) ? fine_ctl_r[2*c]   : coarse_ctl_r[2*c];
                assign limit   = dur_cycles((g == 0) ? fine_code : coarse_code);
                // Fire directly, or on sync once armed by a rising control bit
                assign fire = sync_sel ? (armed_r & sync_edge)
                                       : (en_bit & ~en_d_r);

                // Arm on control bit rise; clearing the bit disarms
                always_ff @(posedge clk_sys_i) begin
                    if (sys_rst_i) begin
                        en_d_r  <= 1'b0;
                        armed_r <= 1'b0;
                    end else begin
                        en_d_r <= en_bit;
                        if (!en_bit || fire) begin
                            armed_r <= 1'b0;
                        end else if (en_bit && !en_d_r) begin
                            armed_r <= 1'b1;
                        end
                    end
                end

                // On-time counter, switches off at limit
                always_ff @(posedge clk_sys_i) begin
                    if (sys_rst_i) begin
                        on_r  <= 1'b0;
                        cnt_r <= `CTR_RST_COUNT;
                    end else if (fire && !on_r) begin
                        on_r  <= 1'b1;
                        cnt_r <= `CTR_COUNT_ONE;
                    end else if (on_r) begin
                        if (cnt_r >= limit) begin
                            on_r  <= 1'b0;
                            cnt_r <= `CTR_RST_COUNT;
                        end else begin
                            cnt_r <= cnt_r + `CTR_COUNT_ONE;
                        end
                    end
                end

                // Registered drive; direction valid only while enabled
                // Each group writes only its own output, so no element has two drivers
                if (g == 0) begin : g_fine_drv
                    always_ff @(posedge clk_sys_i) begin
                        if (sys_rst_i) begin
                            fine_clamp_o[c] <= '0;
                        end else begin
                            fine_clamp_o[c].on <= on_r;
                            fine_clamp_o[c].up <= en_bit & dir_bit;
                        end
                    end
                end else begin : g_coarse_drv
                    always_ff @(posedge clk_sys_i) begin
                        if (sys_rst_i) begin
                            coarse_clamp_o[c] <= '0;
                        end else begin
                            coarse_clamp_o[c].on <= on_r;
                            coarse_clamp_o[c].up <= en_bit & dir_bit;
                        end
                    end
                end
            end
        end
    endgenerate

endmodule // ctr_clamp_regs

/* File: ctr_clamp_regs_assertions.sv */
// Purpose: Port-level checks of the clamp and register block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Shadows of written config bytes feed the checks
module ctr_clamp_regs_assertions
    import ctr_pkg::*;
#(
    parameter int NCLAMP = 3
) (
    input wire logic       clk_sys_i,
    input wire logic       sys_rst_i,
    input wire ctr_req_s   req_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rvalid_o,
    input wire logic       sync_in_i,
    input wire logic       aux_we_i,
    input wire logic [2:0] aux_sel_i,
    input wire logic [7:0] aux_data_i,
    input wire logic [1:0] core_clock_delay_sel_o,
    input wire logic [2:0] adc_reference_trim_o,
    input wire ctr_clamp_s [NCLAMP-1:0] fine_clamp_o,
    input wire ctr_clamp_s [NCLAMP-1:0] coarse_clamp_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cfg_r, mode_r, ctl_r, crs_r, age_r;
    logic [7:0] aux_r [8];
    logic [8:0] len_r;
    logic       sync_d_r;
    wire logic  sync_edge = mode_r[5] ? sync_in_i & ~sync_d_r : sync_d_r & ~sync_in_i;

    // Shadows, on-time count and cycles since the selected sync edge
    always_ff @(posedge clk_sys_i) begin
        sync_d_r <= sync_in_i;
        len_r <= fine_clamp_o[0].on ? len_r + 9'h001 : 9'h000;
        if (aux_we_i) aux_r[aux_sel_i] <= aux_data_i;
        if (req_i.wr && req_i.addr == 5'h07) cfg_r <= req_i.wdata;
        if (req_i.wr && req_i.addr == 5'h08) ctl_r <= req_i.wdata;
        if (req_i.wr && req_i.addr == 5'h09) crs_r <= req_i.wdata;
        if (req_i.wr && req_i.addr == 5'h03) mode_r <= req_i.wdata;
        age_r <= sync_edge ? 8'h00 : age_r + {7'h00, age_r != 8'hff};
        if (sys_rst_i) begin
            cfg_r <= 8'h00;
            ctl_r <= 8'h00;
            crs_r <= 8'h00;
            mode_r <= 8'h00;
            age_r <= 8'hff;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_arm;
        req_i.wr && req_i.addr == 5'h08 && req_i.wdata[1] && !ctl_r[1] && !cfg_r[6]
            && !fine_clamp_o[0].on;
    endsequence
    sequence s_sync_start;
        $rose(fine_clamp_o[0].on) && cfg_r[6];
    endsequence
    property p_aux;
        logic [7:0] v;
        (req_i.rd && req_i.addr[4:3] == 2'b10, v = aux_r[req_i.addr[2:0]]) |-> ##2 rdata_o == v;
    endproperty
    a_read_latency: assert property (req_i.rd |-> ##2 rvalid_o)
        else $error("read answer missing");
    a_delay_field: assert property (req_i.wr && req_i.addr == 5'h0a |->
        ##2 core_clock_delay_sel_o == $past(req_i.wdata[6:5], 2)) else $error("delay select");
    a_trim_field: assert property (req_i.wr && req_i.addr == 5'h0b |->
        ##2 adc_reference_trim_o == $past(req_i.wdata[6:4], 2)) else $error("trim field");
    a_aux_result: assert property (p_aux)
        else $error("aux result wrong");
    a_fine_length: assert property ($fell(fine_clamp_o[0].on) |->
        len_r == 9'h002 << cfg_r[2:0]) else $error("clamp on-time wrong");
    a_up_gated: assert property (fine_clamp_o[0].up == (&$past(ctl_r[1:0]))
        && coarse_clamp_o[0].up == (&$past(crs_r[1:0]))) else $error("up not enable and dir");
    a_sync_fire: assert property (s_sync_start |-> age_r <= 8'h08)
        else $error("clamp fired without sync edge");
    a_direct_fire: assert property (s_arm |-> ##[2:3] fine_clamp_o[0].on)
        else $error("clamp did not fire");
endmodule // ctr_clamp_regs_assertions

bind ctr_clamp_regs ctr_clamp_regs_assertions #(.NCLAMP(NCLAMP)) u_chk (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .sync_in_i(sync_in_i), .aux_we_i(aux_we_i), .aux_sel_i(aux_sel_i),
    .aux_data_i(aux_data_i), .core_clock_delay_sel_o(core_clock_delay_sel_o),
    .adc_reference_trim_o(adc_reference_trim_o), .fine_clamp_o(fine_clamp_o),
    .coarse_clamp_o(coarse_clamp_o));

/* File: ctr_host_model.sv */
// Purpose: Host issuing one-cycle register requests
// Assumes: Requests change on the falling clock edge
// Notes:   Reserved bits are forced to their required values
module ctr_host_model
    import ctr_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output ctr_req_s        req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req_o = '0;

    // Write pulse, one idle cycle after it
    task automatic wr(input logic [4:0] a, input logic [7:0] dat);
        logic [7:0] v;
        v = dat;
        if (a == 5'h0a) v = v & 8'h6b;
        if (a == 5'h0b) v = (v & 8'h70) | 8'h01;
        @(negedge clk_sys_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clk_sys_i);
        req_o = '0;
    endtask

    // Read pulse, answer taken while rvalid stands
    task automatic rd(input logic [4:0] a, output logic [7:0] dat);
        @(negedge clk_sys_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys_i);
        req_o = '0;
        dat = 8'hxx;
        repeat (4) begin
            @(negedge clk_sys_i);
            if (rvalid_i === 1'b1) dat = rdata_i;
        end
    endtask
endmodule // ctr_host_model

/* File: ctr_tb.sv */
// Purpose: Self-checking bench for the clamp and register block
// Assumes: Host model drives all register traffic
// Notes:   Inputs change on the falling clock edge
module testbench
    import ctr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i, sys_rst_i, sync_in_i, aux_we_i, rvalid_o, up;
    logic [2:0] aux_sel_i, adc_reference_trim_o;
    logic [7:0] aux_data_i, rdata_o, d;
    logic [1:0] core_clock_delay_sel_o;
    ctr_req_s   req_i;
    ctr_clamp_s [2:0] fine_clamp_o, coarse_clamp_o;
    int errors, compares, len;

    ctr_clamp_regs uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .sync_in_i(sync_in_i), .aux_we_i(aux_we_i),
        .aux_sel_i(aux_sel_i), .aux_data_i(aux_data_i),
        .core_clock_delay_sel_o(core_clock_delay_sel_o),
        .adc_reference_trim_o(adc_reference_trim_o), .fine_clamp_o(fine_clamp_o),
        .coarse_clamp_o(coarse_clamp_o));
    ctr_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .req_o(req_i));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Clear then set a control byte so the trigger bit rises
    task automatic rearm(input logic [4:0] a, input logic [7:0] v);
        host.wr(a, 8'h00);
        host.wr(a, v);
    endtask

    // Length of the next on pulse of clamp 0, zero if none starts
    task automatic measure(input bit crs, output int n, output logic u);
        ctr_clamp_s c;
        n = 0;
        u = 1'b0;
        for (int i = 0; i < 700; i++) begin
            @(negedge clk_sys_i);
            c = crs ? coarse_clamp_o[0] : fine_clamp_o[0];
            if (c.on === 1'b1) begin
                n++;
                u = u | c.up;
            end else if (n > 0 || i > 12) break;
        end
    endtask

    // Clock and watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #1000000;
        errors++;
        summarize();
    end

    // Test sequence
    initial begin
        errors = 0;
        compares = 0;
        sys_rst_i = 1'b1;
        sync_in_i = 1'b0;
        aux_we_i = 1'b0;
        aux_sel_i = 3'h0;
        aux_data_i = 8'h00;
        repeat (6) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        check(core_clock_delay_sel_o, 2'h0);
        host.rd(5'h0b, d);
        check(d, 8'h01);
        host.wr(5'h0a, 8'hff);
        host.wr(5'h0b, 8'hff);
        @(negedge clk_sys_i);
        check(core_clock_delay_sel_o, 2'h3);
        check(adc_reference_trim_o, 3'h7);
        host.rd(5'h0a, d);
        check(d, 8'h6b);
        host.rd(5'h0b, d);
        check(d, 8'h71);
        for (int n = 0; n < 8; n++) begin
            @(negedge clk_sys_i);
            aux_we_i = 1'b1;
            aux_sel_i = n[2:0];
            aux_data_i = 8'h5a ^ n[7:0];
        end
        @(negedge clk_sys_i);
        aux_we_i = 1'b0;
        host.wr(5'h12, 8'h00);
        for (int n = 0; n < 8; n++) begin
            host.rd(5'h10 + n[4:0], d);
            check(d, 8'h5a ^ n[7:0]);
        end
        host.rd(5'h1f, d);
        check(d, 8'h00);
        for (int k = 0; k < 8; k++) begin
            host.wr(5'h07, k[7:0]);
            rearm(5'h08, 8'h03);
            measure(1'b0, len, up);
            check(len, 16'h2 << k);
            check(up, 1'b1);
        end
        host.wr(5'h08, 8'h03);
        measure(1'b0, len, up);
        check(len, 16'h0);
        rearm(5'h08, 8'h02);
        measure(1'b0, len, up);
        check(up, 1'b0);
        host.wr(5'h07, 8'h08);
        rearm(5'h09, 8'h02);
        measure(1'b1, len, up);
        check(len, 16'h4);
        host.wr(5'h03, 8'h20);
        host.wr(5'h07, 8'h40);
        rearm(5'h08, 8'h02);
        measure(1'b0, len, up);
        check(len, 16'h0);
        sync_in_i = 1'b1;
        measure(1'b0, len, up);
        check(len, 16'h2);
        sync_in_i = 1'b0;
        host.wr(5'h03, 8'h00);
        rearm(5'h08, 8'h02);
        sync_in_i = 1'b1;
        measure(1'b0, len, up);
        check(len, 16'h0);
        sync_in_i = 1'b0;
        measure(1'b0, len, up);
        check(len, 16'h2);
        host.wr(5'h07, 8'h00);
        rearm(5'h08, 8'h3c);
        repeat (2) @(negedge clk_sys_i);
        check(fine_clamp_o, 16'h003c);
        rearm(5'h09, 8'h3c);
        repeat (2) @(negedge clk_sys_i);
        check(coarse_clamp_o, 16'h003c);
        summarize();
    end
endmodule // testbench
